// *** rtl/cfg_ahb_slave.sv ***
// ahb-lite slave front end: one wait state, then a registered answer
module cfg_ahb_slave
  import cfg_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // ahb-lite
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  // register side
  input wire logic [31:0] i_rd_data,
  output logic [4:0] o_index,
  output logic o_wr_en,
  output logic [3:0] o_wr_data
);

  bus_st_t st_reg;
  bus_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.wr_en = 1'b0;
    case (st_reg.state)
      BUS_IDLE: begin
        if (i_hsel && i_htrans[1] && i_hready) begin
          st_next.state = BUS_WAIT;
          st_next.ready = 1'b0;
          st_next.write = i_hwrite;
          st_next.index = i_haddr[6:2];
        end
      end
      BUS_WAIT: begin
        // the whole nibble lands at once
        st_next.state = BUS_IDLE;
        st_next.ready = 1'b1;
        st_next.wr_en = st_reg.write;
        st_next.wr_data = i_hwdata[3:0];
        st_next.rdata = st_reg.write ? 32'h0000_0000 : i_rd_data;
      end
      default: begin
        st_next.state = BUS_IDLE;
        st_next.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      st_reg <= '0;
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_hreadyout = st_reg.ready;
  assign o_hrdata = st_reg.rdata;
  assign o_index = st_reg.index;
  assign o_wr_en = st_reg.wr_en;
  assign o_wr_data = st_reg.wr_data;

endmodule

// *** rtl/cfg_bank.sv ***
// decoder pin and mode configuration bank behind an ahb-lite slave
`include "cfg_regs.svh"

module cfg_bank
  import cfg_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // sources inside the decoder
  input wire logic i_offtrack_internal,
  input wire logic i_mute_left,
  input wire logic i_mute_right,
  input wire logic i_motor_line_a,
  input wire logic i_motor_line_b,
  input wire logic i_qw_subcode,
  input wire logic i_deemph_flag,
  input wire logic i_quarter_clock,
  input wire logic i_eleven_clock,
  input wire logic i_sixteen_clock,
  // versatile pins
  input wire logic i_multi_pin_one,
  input wire logic i_dual_pin,
  output logic o_dual_pin_out,
  output logic o_dual_pin_oe,
  output logic o_mute_pin,
  output logic o_multi_pin_four,
  output logic o_multi_pin_five,
  // clock pins
  output logic o_combined_clock,
  output logic o_combined_clock_oe,
  output logic o_sixteen_clock,
  output logic o_sixteen_clock_oe,
  // decoder controls
  output logic o_offtrack,
  output logic o_four_line_motor,
  output logic o_deemph_bypass,
  output logic o_audio_feat_en,
  output logic o_lock_to_disc,
  output logic o_brake_6pct,
  output logic o_subcode_en,
  output logic o_subcode_3wire,
  output logic [1:0] o_pll_loop_code,
  output logic [1:0] o_pll_int_scale
);

  cfg_st_t st_reg;
  cfg_st_t st_next;
  logic [4:0] bus_index;
  logic bus_wr_en;
  logic [3:0] bus_wr_data;
  logic [31:0] rd_data;
  reg_sel_t wr_sel;
  logic pin3_level;

  cfg_ahb_slave cfg_ahb_slave_inst (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .o_hreadyout(o_hreadyout),
    .o_hrdata(o_hrdata),
    .i_rd_data(rd_data),
    .o_index(bus_index),
    .o_wr_en(bus_wr_en),
    .o_wr_data(bus_wr_data)
  );

  // f stays reachable in the shadow space, otherwise the space could never be left
  function automatic reg_sel_t decode(input logic [4:0] idx, input logic alt);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (idx == `IDX_STATUS) begin
      sel = SEL_STATUS;
    end else if (idx == `IDX_SUBC_F) begin
      sel = SEL_SUBC_F;
    end else if (alt) begin
      if (idx == `IDX_SHADOW3) begin
        sel = SEL_SHADOW3;
      end
    end else begin
      case (idx)
        `IDX_PLL: sel = SEL_PLL;
        `IDX_PINS_C: sel = SEL_PINS_C;
        `IDX_PINS_D: sel = SEL_PINS_D;
        `IDX_AUDIO_E: sel = SEL_AUDIO_E;
        default: sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // 01 passes the source, 10 drives low, 11 drives high
  function automatic logic pin_code(input logic [1:0] code, input logic src, input logic dflt);
    logic v;
    v = dflt;
    case (code)
      `PIN_CODE_SRC: v = src;
      `PIN_CODE_LOW: v = 1'b0;
      `PIN_CODE_HIGH: v = 1'b1;
      default: v = dflt;
    endcase
    return v;
  endfunction

  // the slave samples this in its data-phase cycle
  always_comb begin
    rd_data = 32'h0000_0000;
    case (decode(bus_index, st_reg.subc_f[`F_ALT_SPACE]))
      SEL_SHADOW3: rd_data[3:0] = st_reg.shadow3;
      SEL_PLL: rd_data[3:0] = st_reg.pll;
      SEL_PINS_C: rd_data[3:0] = st_reg.pins_c;
      SEL_PINS_D: rd_data[3:0] = st_reg.pins_d;
      SEL_AUDIO_E: rd_data[3:0] = st_reg.audio_e;
      SEL_SUBC_F: rd_data[3:0] = st_reg.subc_f;
      SEL_STATUS: rd_data[2:0] = {st_reg.subc_f[`F_ALT_SPACE], st_reg.p2_sync, st_reg.p1_sync};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  assign wr_sel = bus_wr_en ? decode(bus_index, st_reg.subc_f[`F_ALT_SPACE]) : SEL_NONE;

  // kill-r when split, else the fixed level from c bit2
  assign pin3_level = st_reg.pins_c[`C_SINGLE_MUTE] ? st_reg.pins_c[`C_PIN3_LEVEL]
                                                    : i_mute_right;

  always_comb begin
    st_next = st_reg;
    case (wr_sel)
      SEL_SHADOW3: st_next.shadow3 = bus_wr_data;
      SEL_PLL: st_next.pll = bus_wr_data;
      SEL_PINS_C: st_next.pins_c = bus_wr_data;
      SEL_PINS_D: st_next.pins_d = bus_wr_data;
      SEL_AUDIO_E: st_next.audio_e = bus_wr_data;
      SEL_SUBC_F: st_next.subc_f = bus_wr_data;
      default: st_next.pll = st_reg.pll;
    endcase
    // pins are asynchronous to the decoder clock
    st_next.p1_meta = i_multi_pin_one;
    st_next.p1_sync = st_reg.p1_meta;
    st_next.p2_meta = i_dual_pin;
    st_next.p2_sync = st_reg.p2_meta;
    st_next.offtrack = st_reg.pins_c[`C_EXT_OFFTRACK] ? st_reg.p1_sync
                                                     : i_offtrack_internal;
    // single mute kills only when both channels ask for it
    st_next.mute_pin = st_reg.pins_c[`C_SINGLE_MUTE] ? (i_mute_left & i_mute_right)
                                                     : i_mute_left;
    st_next.dual_oe = st_reg.shadow3[`SH3_PIN3_OUT] & ~pin3_level;
    st_next.four_line = (st_reg.pins_d == `MOTOR_4LINE);
    if (st_reg.pins_d == `MOTOR_4LINE) begin
      st_next.pin_four = i_motor_line_a;
      st_next.pin_five = i_motor_line_b;
    end else begin
      // an undocumented 00 half keeps the motor line on that pin
      st_next.pin_four = pin_code(st_reg.pins_d[1:0], i_qw_subcode, i_motor_line_a);
      st_next.pin_five = pin_code(st_reg.pins_d[3:2], i_deemph_flag, i_motor_line_b);
    end
    st_next.deemph_bypass = (st_reg.pins_d[3:2] == `PIN_CODE_SRC);
    st_next.audio_en = (st_reg.audio_e[3:2] == `AUDIO_ON_CODE);
    // clock sources come from on-chip dividers on i_clock, so no synchroniser
    st_next.comb_clk = st_reg.shadow3[`SH3_ELEVEN_SEL] ? i_eleven_clock
                                                       : i_quarter_clock;
    st_next.comb_oe = ~st_reg.shadow3[`SH3_COMB_HIZ];
    st_next.sixteen_clk = i_sixteen_clock;
    st_next.sixteen_oe = ~st_reg.shadow3[`SH3_SIXTEEN_HIZ];
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      st_reg <= '0;
      st_reg.shadow3 <= `RST_SHADOW3;
      st_reg.pll <= `RST_PLL;
      st_reg.pins_c <= `RST_PINS_C;
      st_reg.pins_d <= `RST_PINS_D;
      st_reg.audio_e <= `RST_AUDIO_E;
      st_reg.subc_f <= `RST_SUBC_F;
      st_reg.mute_pin <= 1'b0;
      st_reg.comb_oe <= 1'b1;
      st_reg.sixteen_oe <= 1'b1;
      st_reg.pin_four <= 1'b1;
      st_reg.pin_five <= 1'b1;
      st_reg.audio_en <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // responses are always okay; open-drain pin only ever pulls low
  assign o_hresp = 1'b0;
  assign o_dual_pin_out = 1'b0;
  assign o_dual_pin_oe = st_reg.dual_oe;
  assign o_mute_pin = st_reg.mute_pin;
  assign o_multi_pin_four = st_reg.pin_four;
  assign o_multi_pin_five = st_reg.pin_five;
  assign o_combined_clock = st_reg.comb_clk;
  assign o_combined_clock_oe = st_reg.comb_oe;
  assign o_sixteen_clock = st_reg.sixteen_clk;
  assign o_sixteen_clock_oe = st_reg.sixteen_oe;
  assign o_offtrack = st_reg.offtrack;
  assign o_four_line_motor = st_reg.four_line;
  assign o_deemph_bypass = st_reg.deemph_bypass;
  assign o_audio_feat_en = st_reg.audio_en;
  assign o_lock_to_disc = st_reg.audio_e[`E_LOCK_DISC];
  assign o_brake_6pct = st_reg.audio_e[`E_BRAKE_6PCT];
  assign o_subcode_en = st_reg.subc_f[`F_SUBC_ON];
  assign o_subcode_3wire = st_reg.subc_f[`F_SUBC_3WIRE];
  assign o_pll_loop_code = st_reg.pll[1:0];
  assign o_pll_int_scale = st_reg.pll[3:2];

  property p_reset_values;
    @(posedge i_clock) $past(!i_rst_b) && i_rst_b |->
      st_reg.pins_c == `RST_PINS_C && st_reg.pins_d == `RST_PINS_D &&
      st_reg.audio_e == `RST_AUDIO_E && st_reg.subc_f == `RST_SUBC_F &&
      st_reg.shadow3 == `RST_SHADOW3;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("configuration not at power-on values after reset");

  property p_offtrack_ext;
    @(posedge i_clock) disable iff (!i_rst_b)
      st_reg.pins_c[`C_EXT_OFFTRACK] |=> o_offtrack == $past(st_reg.p1_sync);
  endproperty
  a_offtrack_ext: assert property (p_offtrack_ext)
    else $error("off-track not taken from pin one");

  property p_split_mute;
    @(posedge i_clock) disable iff (!i_rst_b)
      !st_reg.pins_c[`C_SINGLE_MUTE] ##0 i_mute_left |=> o_mute_pin;
  endproperty
  a_split_mute: assert property (p_split_mute)
    else $error("left mute not on mute pin");

  property p_motor_4line;
    @(posedge i_clock) disable iff (!i_rst_b)
      st_reg.pins_d == `MOTOR_4LINE |=>
        o_four_line_motor && o_multi_pin_four == $past(i_motor_line_a) &&
        o_multi_pin_five == $past(i_motor_line_b);
  endproperty
  a_motor_4line: assert property (p_motor_4line)
    else $error("four-line motor not on pins four and five");

  property p_pin_four_low;
    @(posedge i_clock) disable iff (!i_rst_b)
      st_reg.pins_d[1:0] == `PIN_CODE_LOW |=> !o_multi_pin_four;
  endproperty
  a_pin_four_low: assert property (p_pin_four_low)
    else $error("pin four not low");

  property p_deemph;
    @(posedge i_clock) disable iff (!i_rst_b)
      st_reg.pins_d[3:2] == `PIN_CODE_SRC |=>
        o_deemph_bypass && o_multi_pin_five == $past(i_deemph_flag);
  endproperty
  a_deemph: assert property (p_deemph)
    else $error("de-emphasis flag not on pin five");

  property p_audio_off;
    @(posedge i_clock) disable iff (!i_rst_b)
      st_reg.audio_e[3:2] == 2'h0 |=> !o_audio_feat_en;
  endproperty
  a_audio_off: assert property (p_audio_off)
    else $error("audio features not disabled");

  property p_shadow_write;
    @(posedge i_clock) disable iff (!i_rst_b)
      bus_wr_en && bus_index == `IDX_SHADOW3 && st_reg.subc_f[`F_ALT_SPACE] |=>
        st_reg.shadow3 == $past(bus_wr_data) && $stable(st_reg.pll);
  endproperty
  a_shadow_write: assert property (p_shadow_write)
    else $error("shadow write missed");

  property p_main_write;
    @(posedge i_clock) disable iff (!i_rst_b)
      bus_wr_en && bus_index == `IDX_PINS_D && !st_reg.subc_f[`F_ALT_SPACE] |=>
        st_reg.pins_d == $past(bus_wr_data);
  endproperty
  a_main_write: assert property (p_main_write)
    else $error("register d not written as a whole nibble");

  property p_comb_hiz;
    @(posedge i_clock) disable iff (!i_rst_b)
      st_reg.shadow3[`SH3_COMB_HIZ] |=> !o_combined_clock_oe;
  endproperty
  a_comb_hiz: assert property (p_comb_hiz)
    else $error("combined clock pin still driven");

  property p_comb_eleven;
    @(posedge i_clock) disable iff (!i_rst_b)
      st_reg.shadow3[`SH3_ELEVEN_SEL] |=> o_combined_clock == $past(i_eleven_clock);
  endproperty
  a_comb_eleven: assert property (p_comb_eleven)
    else $error("eleven clock not on combined output");

  property p_sixteen_hiz;
    @(posedge i_clock) disable iff (!i_rst_b)
      st_reg.shadow3[`SH3_SIXTEEN_HIZ] |=> !o_sixteen_clock_oe;
  endproperty
  a_sixteen_hiz: assert property (p_sixteen_hiz)
    else $error("sixteen clock pin still driven");

  property p_dual_input;
    @(posedge i_clock) disable iff (!i_rst_b)
      !st_reg.shadow3[`SH3_PIN3_OUT] |=> !o_dual_pin_oe;
  endproperty
  a_dual_input: assert property (p_dual_input)
    else $error("dual pin driven while an input");

  property p_bus_wait;
    @(posedge i_clock) disable iff (!i_rst_b)
      o_hreadyout && i_hsel && i_htrans[1] |=> !o_hreadyout ##1 o_hreadyout;
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("bus answer not after one wait state");

endmodule

// *** rtl/cfg_pkg.sv ***
// types shared by the configuration bank and its bus slave
package cfg_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01
  } bus_state_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_SHADOW3,
    SEL_PLL,
    SEL_PINS_C,
    SEL_PINS_D,
    SEL_AUDIO_E,
    SEL_SUBC_F,
    SEL_STATUS
  } reg_sel_t;

  typedef struct packed {
    bus_state_t state;
    logic ready;
    logic write;
    logic [4:0] index;
    logic wr_en;
    logic [3:0] wr_data;
    logic [31:0] rdata;
  } bus_st_t;

  typedef struct packed {
    logic [3:0] shadow3;
    logic [3:0] pll;
    logic [3:0] pins_c;
    logic [3:0] pins_d;
    logic [3:0] audio_e;
    logic [3:0] subc_f;
    logic p1_meta;
    logic p1_sync;
    logic p2_meta;
    logic p2_sync;
    logic offtrack;
    logic mute_pin;
    logic dual_oe;
    logic pin_four;
    logic pin_five;
    logic four_line;
    logic deemph_bypass;
    logic audio_en;
    logic comb_clk;
    logic comb_oe;
    logic sixteen_clk;
    logic sixteen_oe;
  } cfg_st_t;

endpackage

// *** rtl/cfg_regs.svh ***
// register indices, field positions and reset values of the decoder configuration bank
`ifndef CFG_REGS_SVH
`define CFG_REGS_SVH

// register index = haddr[6:2]; byte address = 4 * index
`define IDX_SHADOW3 5'h03
`define IDX_PLL 5'h08
`define IDX_PINS_C 5'h0c
`define IDX_PINS_D 5'h0d
`define IDX_AUDIO_E 5'h0e
`define IDX_SUBC_F 5'h0f
`define IDX_STATUS 5'h10

// field positions
`define C_EXT_OFFTRACK 0
`define C_SINGLE_MUTE 1
`define C_PIN3_LEVEL 2
`define E_BRAKE_6PCT 0
`define E_LOCK_DISC 1
`define F_ALT_SPACE 0
`define F_SUBC_ON 2
`define F_SUBC_3WIRE 3
`define SH3_ELEVEN_SEL 0
`define SH3_COMB_HIZ 1
`define SH3_SIXTEEN_HIZ 2
`define SH3_PIN3_OUT 3

// field codes
`define PIN_CODE_SRC 2'h1
`define PIN_CODE_LOW 2'h2
`define PIN_CODE_HIGH 2'h3
`define AUDIO_ON_CODE 2'h1
`define MOTOR_4LINE 4'h0

// power-on values
`define RST_SHADOW3 4'h0
`define RST_PLL 4'h0
`define RST_PINS_C 4'h2
`define RST_PINS_D 4'hf
`define RST_AUDIO_E 4'h4
`define RST_SUBC_F 4'h0

`endif

// *** tb/tb_cfg_bank.sv ***
// self-checking bench for the decoder pin and mode configuration bank
`include "cfg_regs.svh"

module tb_cfg_bank;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_hsel = 1'b0;
  logic i_hwrite = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [31:0] i_hwdata = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic [2:0] i_hsize = 3'h0;
  // source levels: 0 offtrack, 1/2 mutes, 3/4 motor, 5 subcode, 6 deemph,
  // 7..9 clocks, 10 pin one, 11 far-side level on the dual pin
  logic [11:0] ins = 12'h0;
  logic rd_wait = 1'b0;
  logic o_hreadyout, o_hresp, o_dual_pin_out, o_dual_pin_oe, o_mute_pin;
  logic o_multi_pin_four, o_multi_pin_five, o_combined_clock, o_combined_clock_oe;
  logic o_sixteen_clock, o_sixteen_clock_oe, o_offtrack, o_four_line_motor;
  logic o_deemph_bypass, o_audio_feat_en, o_lock_to_disc, o_brake_6pct;
  logic o_subcode_en, o_subcode_3wire;
  logic [1:0] o_pll_loop_code, o_pll_int_scale;
  logic [31:0] o_hrdata;
  wire logic dual_wire;
  wire logic [31:0] obs;
  logic [3:0] c, d, e, f, r8, s3;
  logic [31:0] exp_q[$];
  int errors = 0;
  int n_compared = 0;
  event peek;
  logic [4:0] ix;
  logic [4:0] seq [8] = '{`IDX_PINS_C, `IDX_PINS_D, `IDX_AUDIO_E, `IDX_PLL,
    `IDX_SHADOW3, `IDX_SUBC_F, `IDX_SHADOW3, `IDX_PINS_C};
  logic [4:0] pick [8] = '{`IDX_SHADOW3, 5'h05, `IDX_PLL, `IDX_PINS_C,
    `IDX_PINS_D, `IDX_AUDIO_E, `IDX_SUBC_F, 5'h1f};

  // open drain: the pulled-low level wins over the far side
  assign dual_wire = o_dual_pin_oe ? 1'b0 : ins[11];
  assign obs = {10'h0, o_hresp, o_dual_pin_out, o_offtrack, o_mute_pin, o_dual_pin_oe,
    o_multi_pin_four, o_multi_pin_five, o_four_line_motor, o_deemph_bypass,
    o_audio_feat_en, o_lock_to_disc, o_brake_6pct, o_subcode_en, o_subcode_3wire,
    o_pll_int_scale, o_pll_loop_code, o_combined_clock_oe, o_sixteen_clock_oe,
    o_combined_clock, o_sixteen_clock};

  cfg_bank cfg_bank_inst (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_hrdata(o_hrdata), .i_offtrack_internal(ins[0]), .i_mute_left(ins[1]),
    .i_mute_right(ins[2]), .i_motor_line_a(ins[3]), .i_motor_line_b(ins[4]),
    .i_qw_subcode(ins[5]), .i_deemph_flag(ins[6]), .i_quarter_clock(ins[7]),
    .i_eleven_clock(ins[8]), .i_sixteen_clock(ins[9]), .i_multi_pin_one(ins[10]),
    .i_dual_pin(dual_wire), .o_dual_pin_out(o_dual_pin_out),
    .o_dual_pin_oe(o_dual_pin_oe), .o_mute_pin(o_mute_pin),
    .o_multi_pin_four(o_multi_pin_four), .o_multi_pin_five(o_multi_pin_five),
    .o_combined_clock(o_combined_clock), .o_combined_clock_oe(o_combined_clock_oe),
    .o_sixteen_clock(o_sixteen_clock), .o_sixteen_clock_oe(o_sixteen_clock_oe),
    .o_offtrack(o_offtrack), .o_four_line_motor(o_four_line_motor),
    .o_deemph_bypass(o_deemph_bypass), .o_audio_feat_en(o_audio_feat_en),
    .o_lock_to_disc(o_lock_to_disc), .o_brake_6pct(o_brake_6pct),
    .o_subcode_en(o_subcode_en), .o_subcode_3wire(o_subcode_3wire),
    .o_pll_loop_code(o_pll_loop_code), .o_pll_int_scale(o_pll_int_scale)
  );

  always #5 i_clock = ~i_clock;

  function automatic logic [31:0] exp_pins();
    logic p3, p4, p5;
    p3 = c[1] ? c[2] : ins[2];
    case (d[1:0])
      2'h0: p4 = ins[3];
      2'h1: p4 = ins[5];
      default: p4 = d[0];
    endcase
    case (d[3:2])
      2'h0: p5 = ins[4];
      2'h1: p5 = ins[6];
      default: p5 = d[2];
    endcase
    return {12'h0, c[0] ? ins[10] : ins[0], c[1] ? ins[1] & ins[2] : ins[1],
      s3[3] & ~p3, p4, p5, d == 4'h0, d[3:2] == 2'h1, e[3:2] == 2'h1, e[1], e[0],
      f[2], f[3], r8, ~s3[1], ~s3[2], s3[0] ? ins[8] : ins[7], ins[9]};
  endfunction

  function automatic logic [31:0] stat();
    logic [31:0] p;
    p = exp_pins();
    return {29'h0, f[0], p[17] ? 1'b0 : ins[11], ins[10]};
  endfunction

  // registers outside the selected space read back as zero
  function automatic logic [31:0] exp_reg(input logic [4:0] idx);
    logic [3:0] v;
    v = 4'h0;
    case (idx)
      `IDX_SUBC_F: v = f;
      `IDX_SHADOW3: v = f[0] ? s3 : 4'h0;
      `IDX_PLL: v = f[0] ? 4'h0 : r8;
      `IDX_PINS_C: v = f[0] ? 4'h0 : c;
      `IDX_PINS_D: v = f[0] ? 4'h0 : d;
      `IDX_AUDIO_E: v = f[0] ? 4'h0 : e;
      default: v = 4'h0;
    endcase
    return {28'h0, v};
  endfunction

  task automatic model_reset();
    c = `RST_PINS_C;
    d = `RST_PINS_D;
    e = `RST_AUDIO_E;
    f = `RST_SUBC_F;
    r8 = `RST_PLL;
    s3 = `RST_SHADOW3;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] ex, input string m);
    n_compared++;
    if (got !== ex) begin
      errors++;
      $display("mismatch at %0t ns: %s got %h expected %h", $time, m, got, ex);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one idle edge before each transfer keeps drivers to one assignment per step
  task automatic xfer(input logic w, input logic [4:0] idx, input logic [31:0] wd);
    @(posedge i_clock);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {25'h0, idx, 2'h0};
    i_hwrite <= w;
    i_hsize <= 3'h2;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    rd_wait <= ~w;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    rd_wait <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
    case (idx)
      `IDX_SUBC_F: f = wd[3:0];
      `IDX_SHADOW3: if (f[0]) s3 = wd[3:0];
      `IDX_PLL: if (!f[0]) r8 = wd[3:0];
      `IDX_PINS_C: if (!f[0]) c = wd[3:0];
      `IDX_PINS_D: if (!f[0]) d = wd[3:0];
      `IDX_AUDIO_E: if (!f[0]) e = wd[3:0];
      default: ;
    endcase
  endtask

  task automatic rd(input logic [4:0] idx, input logic [31:0] ex);
    exp_q.push_back(ex);
    xfer(1'b0, idx, 32'h0);
  endtask

  // derived pins land one edge after the register, so two edges are enough
  task automatic look();
    repeat (2) @(posedge i_clock);
    #1;
    exp_q.push_back(exp_pins());
    ->peek;
  endtask

  task automatic rnd();
    @(posedge i_clock);
    ins <= 12'($urandom);
  endtask

  always @(posedge i_clock) begin
    if (rd_wait === 1'b1 && o_hreadyout === 1'b1) begin
      check(o_hrdata, exp_q.pop_front(), "read data");
    end
  end

  always @(peek) begin
    check(obs, exp_q.pop_front(), "pin state");
  end

  initial begin
    #300000;
    errors++;
    results();
  end

  initial begin
    void'($urandom(32'h2e72aa43));
    model_reset();
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    look();
    rd(`IDX_STATUS, stat());
    $display("test reset done");
    // every code of every register, with refused writes in the wrong space
    foreach (seq[k]) begin
      for (int v = 0; v < 16; v++) begin
        rnd();
        wr(seq[k], {28'($urandom), 4'(v)});
        look();
        rd(seq[k], exp_reg(seq[k]));
        if (!f[0]) rd(`IDX_STATUS, stat());
      end
    end
    $display("test sweep done");
    for (int n = 0; n < 40; n++) begin
      rnd();
      ix = pick[$urandom_range(7, 0)];
      wr(ix, $urandom);
      look();
      rd(ix, exp_reg(ix));
      rd(5'h05, 32'h0);
      if (!f[0]) rd(`IDX_STATUS, stat());
    end
    $display("test random done");
    // a second reset in mid-run must bring every field back
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    model_reset();
    look();
    rd(`IDX_PINS_C, exp_reg(`IDX_PINS_C));
    rd(`IDX_STATUS, stat());
    $display("test mid-run reset done");
    results();
  end
endmodule
